// ==== core/fod_pkg.sv ====
/*
 * fod_pkg: shared constants and types for the floating point opcode
 * decode and sequencing block.
 * Assumes one core clock; every clock count below is in core clocks.
 */
package fod_pkg;
   // =====================================================================
   // prefix and escape bytes
   localparam logic [7:0] ESC_D8 = 8'hD8;
   localparam logic [7:0] ESC_D9 = 8'hD9;
   localparam logic [7:0] ESC_DB = 8'hDB;
   localparam logic [7:0] ESC_DC = 8'hDC;
   localparam logic [7:0] ESC_DD = 8'hDD;
   localparam logic [7:0] ESC_DE = 8'hDE;
   localparam logic [7:0] ESC_DF = 8'hDF;
   localparam logic [7:0] WAIT_BYTE = 8'h9B;
   // =====================================================================
   // second bytes of fixed two-byte forms
   localparam logic [7:0] OP2_NOP = 8'hD0;
   localparam logic [7:0] OP2_PATAN = 8'hF3;
   localparam logic [7:0] OP2_PREM = 8'hF8;
   localparam logic [7:0] OP2_PREM1 = 8'hF5;
   localparam logic [7:0] OP2_PTAN = 8'hF2;
   localparam logic [7:0] OP2_RND = 8'hFC;
   localparam logic [7:0] OP2_SCALE = 8'hFD;
   localparam logic [7:0] OP2_SIN = 8'hFE;
   localparam logic [7:0] OP2_SINCOS = 8'hFB;
   localparam logic [7:0] OP2_SQRT = 8'hFA;
   localparam logic [7:0] OP2_STSW_ACC = 8'hE0;
   // =====================================================================
   // modrm fields: mod is [7:6], reg is [5:3], r/m or n is [2:0]
   localparam logic [1:0] MOD_REG = 2'h3;
   localparam logic [2:0] REG_010 = 3'h2;
   localparam logic [2:0] REG_011 = 3'h3;
   localparam logic [2:0] REG_100 = 3'h4;
   localparam logic [2:0] REG_101 = 3'h5;
   localparam logic [2:0] REG_110 = 3'h6;
   localparam logic [2:0] REG_111 = 3'h7;
   // =====================================================================
   // clock counts (min, max) in core clocks
   localparam int CNT_WIDTH = 9;
   localparam logic [8:0] C_NOP = 9'h002;
   localparam logic [8:0] C_WAIT = 9'h002;
   localparam logic [8:0] C_WAIT_ADD = 9'h002;  // extra clocks of the wait-prefixed forms
   localparam logic [8:0] C_ARG_RED = 9'h05A;   // 90 clocks of argument reduction
   localparam logic [8:0] C_PATAN_MIN = 9'h061, C_PATAN_MAX = 9'h0A1;   // 97..161
   localparam logic [8:0] C_PREM_MIN = 9'h052, C_PREM_MAX = 9'h05B;     // 82..91
   localparam logic [8:0] C_PTAN_MIN = 9'h075, C_PTAN_MAX = 9'h081;     // 117..129
   localparam logic [8:0] C_RND_MIN = 9'h00A, C_RND_MAX = 9'h014;       // 10..20
   localparam logic [8:0] C_RSTOR_MIN = 9'h038, C_RSTOR_MAX = 9'h048;   // 56..72
   localparam logic [8:0] C_SAVE_MIN = 9'h037, C_SAVE_MAX = 9'h041;     // 55..65 no wait
   localparam logic [8:0] C_SCALE_MIN = 9'h007, C_SCALE_MAX = 9'h00E;   // 7..14
   localparam logic [8:0] C_SIN_MIN = 9'h04C, C_SIN_MAX = 9'h08C;       // 76..140
   localparam logic [8:0] C_SINCOS_MIN = 9'h091, C_SINCOS_MAX = 9'h0A1; // 145..161
   localparam logic [8:0] C_SQRT_MIN = 9'h03B, C_SQRT_MAX = 9'h03C;     // 59..60
   localparam logic [8:0] C_STORE = 9'h002;
   localparam logic [8:0] C_BCD_MIN = 9'h039, C_BCD_MAX = 9'h03F;       // 57..63
   localparam logic [8:0] C_SI_MIN = 9'h008, C_SI_MAX = 9'h00D;         // 8..13
   localparam logic [8:0] C_WI_MIN = 9'h007, C_WI_MAX = 9'h00A;         // 7..10
   localparam logic [8:0] C_LI_MIN = 9'h00A, C_LI_MAX = 9'h00D;         // 10..13
   localparam logic [8:0] C_STCW = 9'h003;
   localparam logic [8:0] C_STENV_MIN = 9'h00C, C_STENV_MAX = 9'h016;   // 12..22 no wait
   localparam logic [8:0] C_STSW_MEM = 9'h004;
   localparam logic [8:0] C_STSW_ACC = 9'h002;
   localparam logic [8:0] C_SUB_MIN = 9'h004, C_SUB_MAX = 9'h009;       // 4..9
   // =====================================================================
   // reset values
   localparam logic [2:0] TOP_RESET = 3'h0;
   // =====================================================================
   // decoded operation
   typedef enum logic [4:0] {
      OP_NONE = 5'h00, OP_NOP = 5'h01, OP_PATAN = 5'h02, OP_PREM = 5'h03,
      OP_PREM1 = 5'h04, OP_PTAN = 5'h05, OP_RND = 5'h06, OP_RSTOR = 5'h07,
      OP_SAVE = 5'h08, OP_SCALE = 5'h09, OP_SIN = 5'h0A, OP_SINCOS = 5'h0B,
      OP_SQRT = 5'h0C, OP_STORE = 5'h0D, OP_BCD = 5'h0E, OP_IST = 5'h0F,
      OP_STCW = 5'h10, OP_STENV = 5'h11, OP_STSW = 5'h12, OP_SUB = 5'h13,
      OP_WAIT = 5'h14
   } fod_op_t;
   // memory operand format
   typedef enum logic [3:0] {
      MF_NONE = 4'h0, MF_SINGLE = 4'h1, MF_DOUBLE = 4'h2, MF_EXTENDED = 4'h3,
      MF_WORD_INT = 4'h4, MF_SHORT_INT = 4'h5, MF_LONG_INT = 4'h6, MF_BCD = 4'h7,
      MF_ENV = 4'h8, MF_STATE = 4'h9, MF_CONTROL = 4'hA, MF_STATUS = 4'hB
   } fod_mem_t;
   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } fod_state_t;
endpackage

// ==== core/fod_timer.sv ====
/*
 * fod_timer: down counter that measures the clock count of one operation.
 * Assumes load and run are never high together with a zero length.
 */
`timescale 1ns/1ps
`default_nettype none
module fod_timer (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_load,
   input wire logic [fod_pkg::CNT_WIDTH-1:0] i_length,
   output logic o_last
);
   import fod_pkg::*;
   logic [CNT_WIDTH-1:0] remain;
   // =====================================================================
   // counter: loaded with the length, ends when it reaches one
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         remain <= '0;
      end else if (i_load) begin
         remain <= i_length;
      end else if (remain != '0) begin
         remain <= remain - 1'b1;
      end
   end
   assign o_last = (remain == {{(CNT_WIDTH-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// ==== core/fod_stack_ptr.sv ====
/*
 * fod_stack_ptr: top-of-stack pointer of the eight-entry register stack.
 * Assumes at most one of pop, push and load per cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module fod_stack_ptr (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_pop,
   input wire logic i_push,
   input wire logic i_load,
   input wire logic [2:0] i_load_value,
   output logic [2:0] o_top
);
   import fod_pkg::*;
   // =====================================================================
   // pointer: pop moves up, push moves down, wraps modulo eight
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_top <= TOP_RESET;
      end else if (i_load) begin
         o_top <= i_load_value;
      end else if (i_pop) begin
         o_top <= o_top + 3'h1;
      end else if (i_push) begin
         o_top <= o_top - 3'h1;
      end
   end
endmodule
`default_nettype wire

// ==== core/fod_core.sv ====
/*
 * fod_core: decodes the floating point opcode handed over by the integer
 * unit, holds busy for the operation's clock count, and applies the
 * register-stack effect when the operation completes.
 * Assumes the integer unit issues only while o_ready is high, gives the
 * escape byte, the modrm/second byte and a wait-prefix flag in one cycle,
 * and supplies the operand-dependent extra clocks and range flag.
 */
// Functional notes
// - arctangent of element one over top, written to element one, pop; 97-161
// - both remainder forms write remainder of top over element one; 82-91
// - tangent replaces top, then pushes one; 117-129
// - round top to integral value in place; 10-20
// - full restore reloads environment and stack; 56-72
// - full save: 57-67 with wait prefix, 55-65 without
// - scale top by two to element one; 7-14
// - sine replaces top; 76-140
// - sine-cosine writes sine to top then pushes cosine; 145-161
// - square root replaces top; 59-60
// - store top to element, double or single real; 2 clocks
// - store top to element or extended/double/single real, then pop; 2 clocks
// - packed decimal store then pop; 57-63
// - integer store: 32-bit 8-13, 16-bit 7-10
// - popping integer store adds 64-bit form 10-13, then pops
// - control word store: 5 with wait, 3 without
// - environment store: 14-24 with wait, 12-22 without
// - status word to memory: 6 with wait, 4 without
// - status word to accumulator: 4 with wait, 2 without
// - four subtract forms, 4-9 clocks each
// - popping subtract writes element minus top, then pops
// - reverse subtract swaps operand order; 4-9
// - pop increments top pointer, push decrements, popped values discarded
// - trig forms add 90 clocks when argument reduction is needed
// - wait opcode stalls issue until not busy; 2 clocks when idle
`timescale 1ns/1ps
`default_nettype none
module fod_core (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // issue from the integer unit
   input wire logic i_issue,
   input wire logic i_wait_prefix,
   input wire logic [7:0] i_escape,
   input wire logic [7:0] i_modrm,
   input wire logic [7:0] i_extra_clocks,
   input wire logic i_arg_reduce,
   input wire logic [2:0] i_restore_top,
   // status toward the integer unit
   output logic o_ready,
   output logic o_busy,
   output logic o_done,
   output logic o_reserved,
   // decoded operation, held from issue until the next issue; stack top updated at completion
   output fod_pkg::fod_op_t o_op,
   output fod_pkg::fod_mem_t o_mem_fmt,
   output logic o_mem_read,
   output logic o_mem_write,
   output logic o_acc_write,
   output logic o_reverse,
   output logic o_dest_elem,
   output logic [2:0] o_elem_idx,
   output logic o_pop,
   output logic o_push,
   output logic [2:0] o_stack_top
);
   import fod_pkg::*;

   // =====================================================================
   // decode
   fod_op_t dec_op;
   fod_mem_t dec_fmt;
   logic dec_valid, dec_pop, dec_push, dec_rev, dec_dest_elem, dec_waitable, dec_trig;
   logic dec_mem_rd, dec_mem_wr, dec_acc_wr;
   logic [8:0] dec_min, dec_max;
   logic is_mem;
   logic [2:0] reg_fld;

   assign is_mem = (i_modrm[7:6] != MOD_REG);
   assign reg_fld = i_modrm[5:3];

   // one table keyed on escape byte, modrm form and reg field
   always_comb begin
      dec_op = OP_NONE;
      dec_fmt = MF_NONE;
      dec_valid = 1'b1;
      dec_pop = 1'b0;
      dec_push = 1'b0;
      dec_rev = 1'b0;
      dec_dest_elem = 1'b0;
      dec_waitable = 1'b0;
      dec_trig = 1'b0;
      dec_mem_rd = 1'b0;
      dec_mem_wr = 1'b0;
      dec_acc_wr = 1'b0;
      dec_min = C_NOP;
      dec_max = C_NOP;
      if (i_escape == WAIT_BYTE) begin
         dec_op = OP_WAIT;
         dec_min = C_WAIT;
         dec_max = C_WAIT;
      end else if (i_escape == ESC_D9 && !is_mem) begin
         case (i_modrm)
            OP2_NOP: begin
               dec_op = OP_NOP;
            end
            OP2_PATAN: begin
               dec_op = OP_PATAN;
               dec_pop = 1'b1;
               dec_min = C_PATAN_MIN;
               dec_max = C_PATAN_MAX;
            end
            OP2_PREM, OP2_PREM1: begin
               dec_op = (i_modrm == OP2_PREM) ? OP_PREM : OP_PREM1;
               dec_min = C_PREM_MIN;
               dec_max = C_PREM_MAX;
            end
            OP2_PTAN: begin
               dec_op = OP_PTAN;
               dec_push = 1'b1;
               dec_trig = 1'b1;
               dec_min = C_PTAN_MIN;
               dec_max = C_PTAN_MAX;
            end
            OP2_RND: begin
               dec_op = OP_RND;
               dec_min = C_RND_MIN;
               dec_max = C_RND_MAX;
            end
            OP2_SCALE: begin
               dec_op = OP_SCALE;
               dec_min = C_SCALE_MIN;
               dec_max = C_SCALE_MAX;
            end
            OP2_SIN: begin
               dec_op = OP_SIN;
               dec_trig = 1'b1;
               dec_min = C_SIN_MIN;
               dec_max = C_SIN_MAX;
            end
            OP2_SINCOS: begin
               dec_op = OP_SINCOS;
               dec_push = 1'b1;
               dec_trig = 1'b1;
               dec_min = C_SINCOS_MIN;
               dec_max = C_SINCOS_MAX;
            end
            OP2_SQRT: begin
               dec_op = OP_SQRT;
               dec_min = C_SQRT_MIN;
               dec_max = C_SQRT_MAX;
            end
            default: begin
               dec_valid = 1'b0;
            end
         endcase
      end else if (i_escape == ESC_D9) begin
         dec_mem_wr = 1'b1;
         if (reg_fld == REG_010 || reg_fld == REG_011) begin
            dec_op = OP_STORE;
            dec_fmt = MF_SINGLE;
            dec_pop = reg_fld[0];
            dec_min = C_STORE;
            dec_max = C_STORE;
         end else if (reg_fld == REG_111) begin
            dec_op = OP_STCW;
            dec_fmt = MF_CONTROL;
            dec_waitable = 1'b1;
            dec_min = C_STCW;
            dec_max = C_STCW;
         end else if (reg_fld == REG_110) begin
            dec_op = OP_STENV;
            dec_fmt = MF_ENV;
            dec_waitable = 1'b1;
            dec_min = C_STENV_MIN;
            dec_max = C_STENV_MAX;
         end else begin
            dec_valid = 1'b0;
         end
      end else if (i_escape == ESC_DB) begin
         if (!is_mem && reg_fld == REG_011) begin
            dec_op = OP_STORE;
            dec_pop = 1'b1;
            dec_dest_elem = 1'b1;
            dec_min = C_STORE;
            dec_max = C_STORE;
         end else if (is_mem && reg_fld == REG_111) begin
            dec_op = OP_STORE;
            dec_fmt = MF_EXTENDED;
            dec_pop = 1'b1;
            dec_mem_wr = 1'b1;
            dec_min = C_STORE;
            dec_max = C_STORE;
         end else if (is_mem && (reg_fld == REG_010 || reg_fld == REG_011)) begin
            dec_op = OP_IST;
            dec_fmt = MF_SHORT_INT;
            dec_pop = reg_fld[0];
            dec_mem_wr = 1'b1;
            dec_min = C_SI_MIN;
            dec_max = C_SI_MAX;
         end else begin
            dec_valid = 1'b0;
         end
      end else if (i_escape == ESC_DD) begin
         if (!is_mem && reg_fld == REG_010) begin
            dec_op = OP_STORE;
            dec_dest_elem = 1'b1;
            dec_min = C_STORE;
            dec_max = C_STORE;
         end else if (is_mem && reg_fld == REG_100) begin
            dec_op = OP_RSTOR;
            dec_fmt = MF_STATE;
            dec_mem_rd = 1'b1;
            dec_min = C_RSTOR_MIN;
            dec_max = C_RSTOR_MAX;
         end else if (is_mem && reg_fld == REG_110) begin
            dec_op = OP_SAVE;
            dec_fmt = MF_STATE;
            dec_mem_wr = 1'b1;
            dec_waitable = 1'b1;
            dec_min = C_SAVE_MIN;
            dec_max = C_SAVE_MAX;
         end else if (is_mem && (reg_fld == REG_010 || reg_fld == REG_011)) begin
            dec_op = OP_STORE;
            dec_fmt = MF_DOUBLE;
            dec_pop = reg_fld[0];
            dec_mem_wr = 1'b1;
            dec_min = C_STORE;
            dec_max = C_STORE;
         end else if (is_mem && reg_fld == REG_111) begin
            dec_op = OP_STSW;
            dec_fmt = MF_STATUS;
            dec_mem_wr = 1'b1;
            dec_waitable = 1'b1;
            dec_min = C_STSW_MEM;
            dec_max = C_STSW_MEM;
         end else begin
            dec_valid = 1'b0;
         end
      end else if (i_escape == ESC_DF) begin
         dec_mem_wr = is_mem;
         dec_pop = is_mem;
         if (i_modrm == OP2_STSW_ACC) begin
            dec_op = OP_STSW;
            dec_acc_wr = 1'b1;
            dec_waitable = 1'b1;
            dec_min = C_STSW_ACC;
            dec_max = C_STSW_ACC;
         end else if (is_mem && reg_fld == REG_110) begin
            dec_op = OP_BCD;
            dec_fmt = MF_BCD;
            dec_min = C_BCD_MIN;
            dec_max = C_BCD_MAX;
         end else if (is_mem && reg_fld == REG_111) begin
            dec_op = OP_IST;
            dec_fmt = MF_LONG_INT;
            dec_min = C_LI_MIN;
            dec_max = C_LI_MAX;
         end else if (is_mem && (reg_fld == REG_010 || reg_fld == REG_011)) begin
            dec_op = OP_IST;
            dec_fmt = MF_WORD_INT;
            dec_pop = reg_fld[0];
            dec_min = C_WI_MIN;
            dec_max = C_WI_MAX;
         end else begin
            dec_valid = 1'b0;
         end
      end else if (i_escape == ESC_D8 || i_escape == ESC_DC || i_escape == ESC_DE) begin
         // sub: reg 100 forward, reg 101 reverse for memory forms; register
         // forms with reg 101 write the element, reg 100 write the top
         dec_op = OP_SUB;
         dec_min = C_SUB_MIN;
         dec_max = C_SUB_MAX;
         dec_fmt = (i_escape == ESC_D8) ? MF_SINGLE : MF_DOUBLE;
         dec_mem_rd = is_mem;
         if (is_mem) begin
            dec_rev = (reg_fld == REG_101);
            dec_valid = (i_escape != ESC_DE) && (reg_fld == REG_100 || reg_fld == REG_101);
         end else begin
            dec_fmt = MF_NONE;
            dec_dest_elem = (reg_fld == REG_101);
            dec_rev = (i_escape == ESC_D8) ? (reg_fld == REG_101) : (reg_fld == REG_100);
            dec_pop = (i_escape == ESC_DE);
            dec_valid = (reg_fld == REG_100 || reg_fld == REG_101)
                        && !(i_escape == ESC_DE && reg_fld == REG_100);
         end
      end else begin
         dec_valid = 1'b0;
      end
   end

   // =====================================================================
   // clock count of the issued form
   logic [8:0] span, extra, length;
   assign span = dec_max - dec_min;
   assign extra = ({1'b0, i_extra_clocks} > span) ? span : {1'b0, i_extra_clocks};
   // operand-dependent clocks are clamped, so a bad hint never leaves the range
   assign length = dec_min + extra
                   + ((dec_trig && i_arg_reduce) ? C_ARG_RED : 9'h000)
                   + ((dec_waitable && i_wait_prefix) ? C_WAIT_ADD : 9'h000);

   // =====================================================================
   // sequencer
   fod_state_t state;
   logic accept, timer_last, finish;
   assign accept = i_issue && o_ready && (state == ST_IDLE) && dec_valid;
   assign finish = (state == ST_RUN) && timer_last;

   fod_timer u_timer (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_load(accept),
      .i_length(length),
      .o_last(timer_last)
   );

   // state: busy runs exactly the counted clocks after the issue edge
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (accept) begin
                  state <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (timer_last) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // handshake flags toward the integer unit
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_ready <= 1'b1;
         o_busy <= 1'b0;
         o_done <= 1'b0;
         o_reserved <= 1'b0;
      end else begin
         o_done <= finish;
         o_reserved <= i_issue && o_ready && !dec_valid;
         if (accept) begin
            o_busy <= 1'b1;
            o_ready <= 1'b0;
         end else if (finish) begin
            o_busy <= 1'b0;
            o_ready <= 1'b1;
         end
      end
   end

   // decoded fields captured at issue and held for the data path
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_op <= OP_NONE;
         o_mem_fmt <= MF_NONE;
         o_mem_read <= 1'b0;
         o_mem_write <= 1'b0;
         o_acc_write <= 1'b0;
         o_reverse <= 1'b0;
         o_dest_elem <= 1'b0;
         o_elem_idx <= 3'h0;
         o_pop <= 1'b0;
         o_push <= 1'b0;
      end else if (accept) begin
         o_op <= dec_op;
         o_mem_fmt <= dec_fmt;
         o_mem_read <= dec_mem_rd;
         o_mem_write <= dec_mem_wr;
         o_acc_write <= dec_acc_wr;
         o_reverse <= dec_rev;
         o_dest_elem <= dec_dest_elem;
         o_elem_idx <= is_mem ? 3'h1 : i_modrm[2:0];
         o_pop <= dec_pop;
         o_push <= dec_push;
      end
   end

   // =====================================================================
   // stack pointer moves only at completion; restore reloads it
   fod_stack_ptr u_stack (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_pop(finish && o_pop),
      .i_push(finish && o_push),
      .i_load(finish && o_op == OP_RSTOR),
      .i_load_value(i_restore_top),
      .o_top(o_stack_top)
   );
endmodule
`default_nettype wire

// ==== verification/fod_core_props.sv ====
/* fod_core_props: port timing checks of fod_core.
   Assumes one core clock domain; bound in below. */
`timescale 1ns/1ps
`default_nettype none
module fod_core_props (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_issue,
   input wire logic [7:0] i_escape,
   input wire logic [7:0] i_modrm,
   input wire logic [7:0] i_extra_clocks,
   input wire logic o_ready,
   input wire logic o_busy,
   input wire logic o_done,
   input wire logic o_reserved,
   input wire logic o_pop,
   input wire logic [2:0] o_stack_top
);
   // ==========
   // issue and completion
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   logic take;
   assign take = i_issue && o_ready;
   sequence sqrt_take_s;
      take && i_escape == 8'hD9 && i_modrm == 8'hFA && i_extra_clocks == 8'h00;
   endsequence
   sequence finish_s;
      o_done && !o_busy && o_ready;
   endsequence
   // ==========
   // handshake, counts, stack pointer
   busy_from_issue_a: assert property ($rose(o_busy) |-> $past(take)) else $error("busy without issue");
   done_ends_busy_a: assert property (o_done |-> !o_busy && o_ready && $past(o_busy)) else $error("done");
   done_one_cycle_a: assert property (o_done |=> !o_done) else $error("done too long");
   busy_blocks_a: assert property (o_busy |-> !o_ready) else $error("ready while busy");
   reserved_quiet_a: assert property (o_reserved |-> !o_busy && o_ready) else $error("reserved");
   sqrt_count_a: assert property (sqrt_take_s |=> o_busy ##58 o_busy ##1 finish_s) else $error("sqrt");
   nop_count_a: assert property (take && i_escape == 8'hD9 && i_modrm == 8'hD0 |-> ##3 finish_s)
      else $error("nop");
   pop_step_a: assert property (o_done && o_pop |-> o_stack_top == 3'($past(o_stack_top) + 3'h1))
      else $error("pop step");
endmodule
bind fod_core fod_core_props u_props (.i_clk_sys, .i_rst, .i_issue, .i_escape, .i_modrm, .i_extra_clocks,
   .o_ready, .o_busy, .o_done, .o_reserved, .o_pop, .o_stack_top);
`default_nettype wire

// ==== verification/fod_int_unit.sv ====
/* fod_int_unit: integer unit model issuing opcodes.
   Assumes the bench calls send; idle lines carry inverted values. */
`timescale 1ns/1ps
`default_nettype none
module fod_int_unit (
   input wire logic i_clk_sys,
   input wire logic i_ready,
   output logic o_issue,
   output logic o_wait_prefix,
   output logic [7:0] o_escape,
   output logic [7:0] o_modrm,
   output logic [7:0] o_extra_clocks,
   output logic o_arg_reduce,
   output logic [2:0] o_restore_top
);
   // ==========
   // idle at time zero
   initial begin
      {o_issue, o_wait_prefix, o_escape, o_modrm, o_extra_clocks, o_arg_reduce, o_restore_top} = '0;
   end
   // restore top held past issue, since it is read at completion
   task automatic send(input logic [7:0] e, input logic [7:0] m, input logic w, input logic [7:0] x,
      input logic a, input logic [2:0] r);
      @(posedge i_clk_sys);
      o_issue <= 1'b1;
      {o_escape, o_modrm, o_wait_prefix, o_extra_clocks, o_arg_reduce, o_restore_top} <= {e, m, w, x, a, r};
      do @(posedge i_clk_sys); while (!i_ready);
      o_issue <= 1'b0;
      {o_escape, o_modrm, o_wait_prefix, o_extra_clocks, o_arg_reduce} <= ~{e, m, w, x, a};
   endtask
endmodule
`default_nettype wire

// ==== verification/fpu_opcode_decode_timing_test.sv ====
/* fpu_opcode_decode_timing_test: table model of counts and stack pointer.
   Assumes fod_int_unit drives the issue side. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR %s exp %0d got %0d", nm, e, g); end end
module fpu_opcode_decode_timing_test;
   import fod_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic iss, wp, ar, rdy, busy, done, rsv, pp, pu, de, aw;
   logic [7:0] esc, md, ex;
   logic [2:0] rt, top, ei;
   logic [2:0] m_top = 3'h0;
   int seed = 32'h1527b1ad;
   int n_mismatch = 0;
   int tests_run = 0;
   // escape, modrm, min, max, flags: trig, waitable, pop, push, n free, mod free, restore, dest element
   logic [39:0] tbl [39] = '{40'hD9D0020200, 40'hD9F361A104, 40'hD9F8525B00, 40'hD9F5525B00, 40'hD9F2758109,
      40'hD9FC0A1400, 40'hDD20384870, 40'hDD30374132, 40'hD9FD070E00, 40'hD9FE4C8C01, 40'hD9FB91A109,
      40'hD9FA3B3C00, 40'hDDD0020290, 40'hDD10020230, 40'hD910020230, 40'hDBD8020294, 40'hDB38020234,
      40'hDD18020234, 40'hD918020234, 40'hDF30393F34, 40'hDB10080D30, 40'hDF10070A30, 40'hDF380A0D34,
      40'hDB18080D34, 40'hDF18070A34, 40'hD938030332, 40'hD9300C1632, 40'hDD38040432, 40'hDFE0020202,
      40'hDCE8040990, 40'hD8E0040910, 40'hDC20040930, 40'hD820040930, 40'hDEE8040994, 40'hDCE0040910,
      40'hD8E8040990, 40'hDC28040930, 40'hD828040930, 40'h9B00020200};
   fod_int_unit u_iu (.i_clk_sys, .i_ready(rdy), .o_issue(iss), .o_wait_prefix(wp), .o_escape(esc), .o_modrm(md),
      .o_extra_clocks(ex), .o_arg_reduce(ar), .o_restore_top(rt));
   fod_core u_dut (.i_clk_sys, .i_rst, .i_issue(iss), .i_wait_prefix(wp), .i_escape(esc), .i_modrm(md),
      .i_extra_clocks(ex), .i_arg_reduce(ar), .i_restore_top(rt), .o_ready(rdy), .o_busy(busy), .o_done(done),
      .o_reserved(rsv), .o_op(), .o_mem_fmt(), .o_mem_read(), .o_mem_write(), .o_acc_write(aw), .o_reverse(),
      .o_dest_elem(de), .o_elem_idx(ei), .o_pop(pp), .o_push(pu), .o_stack_top(top));
   // ==========
   // clock and watchdog; 118 ops of at most 253 clocks stay under 30k clocks
   initial begin
      forever #2.5 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      #150_000;
      n_mismatch++;
      summarize();
   end
   // ==========
   // one random operation against the table
   task automatic run_op(input logic [39:0] t, input int p);
      logic [7:0] m, x;
      logic w, a;
      logic [2:0] r;
      int n, c;
      m = t[31:24];
      if (t[4]) m[2:0] = 3'($random(seed));
      if (t[5]) m[7:6] = 2'({$random(seed)} % 3);
      x = (p == 0) ? 8'h00 : 8'($random(seed));
      {w, a, r} = 5'($random(seed));
      n = t[23:16] + ((x < t[15:8] - t[23:16]) ? x : t[15:8] - t[23:16]);
      n += (t[0] && a) ? 90 : 0;
      n += (t[1] && w) ? 2 : 0;
      m_top = t[6] ? r : m_top + 3'(t[2]) - 3'(t[3]);
      u_iu.send(t[39:32], m, w, x, a, r);
      c = 0;
      do begin
         @(posedge i_clk_sys);
         c++;
         #1;
      end while (!done && c < 400);
      `CHK("cycles", n, c)
      `CHK("top", m_top, top)
      `CHK("pop", t[2], pp)
      `CHK("push", t[3], pu)
      `CHK("dest", t[7], de)
      `CHK("elem", (m[7:6] == 2'h3) ? m[2:0] : 3'h1, ei)
      `CHK("acc", t[39:24] == 16'hDFE0, aw)
   endtask
   task automatic summarize();
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      for (int p = 0; p < 3; p++) begin
         foreach (tbl[k]) run_op(tbl[k], p);
      end
      // reserved form: flagged, nothing starts
      u_iu.send(8'hDE, 8'hE3, 1'b0, 8'h00, 1'b0, 3'h0);
      #1;
      `CHK("reserved", 1'b1, rsv)
      `CHK("busy", 1'b0, busy)
      summarize();
   end
endmodule
`default_nettype wire
